// File: inc/rco_pkg.sv
package rco_pkg;

  // register indices on the plain register port
  localparam logic [3:0] REG_FREQ_SEL = 4'h0;
  localparam logic [3:0] REG_TRIM = 4'h1;
  localparam logic [3:0] REG_MANUAL_EN = 4'h2;
  localparam logic [3:0] REG_SOSC_MODE = 4'h3;
  localparam logic [3:0] REG_REF_CTRL = 4'h4;
  localparam logic [3:0] REG_REF_SRC = 4'h5;

  // reset values
  localparam logic [3:0] FREQ_SEL_RST = 4'h2; // hardware-chosen default
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam logic [5:0] MANUAL_EN_RST = 6'h00;
  localparam logic SOSC_MODE_RST = 1'b0;
  localparam logic REF_EN_RST = 1'b0;
  localparam logic [1:0] DUTY_RST = 2'h2;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [3:0] SRC_RST = 4'h0;

  // field positions
  localparam int FREQ_MSB = 3;
  localparam int TRIM_MSB = 5;
  localparam int MANUAL_LSB = 2; // six manual-on bits in 7:2
  localparam int REF_EN_POS = 7;
  localparam int DUTY_LSB = 3;
  localparam int RATIO_LSB = 0;
  localparam int SRC_MSB = 3;

  // manual-on bit order inside the six-bit group
  localparam int OSC_CONV = 0;
  localparam int OSC_SECONDARY = 1;
  localparam int OSC_LOW = 2;
  localparam int OSC_MID = 3;
  localparam int OSC_HIGH = 4;
  localparam int OSC_EXTERNAL = 5;

  // reference source codes
  localparam logic [3:0] SRC_SYS = 4'h0;
  localparam logic [3:0] SRC_LAST = 4'ha;
  localparam int NUM_EXT_SRC = 10;

  // highest frequency select code that is not reserved
  localparam logic [3:0] FREQ_MAX_CODE = 4'h8;

  // mid-frequency oscillator taps in hertz
  localparam int MID_FAST_HZ = 500000;
  localparam int MID_SLOW_HZ = 31250;

  // oscillator configuration carried to the analog side
  typedef struct packed {
    logic [3:0] hf_freq_select;
    logic [7:0] hf_nominal_mhz;
    logic hf_freq_reserved;
    logic [5:0] trim_offset;
    logic [5:0] osc_run;
    logic secondary_osc_power_mode;
  } rco_osc_cfg_t;

endpackage

// File: rtl/rco_ref_clock.sv
// What this block does
// - frequency select code picks nominal oscillator frequency
// - trim is signed, zero at reset
// - manual-on bits force each oscillator running
// - forced high oscillator uses selected frequency
// - mid oscillator derived from high, two taps
// - forced secondary oscillator follows power mode bit
// - unimplemented bits read zero, writes ignored
// - reference takes selected source, drives output pin
// - reference also feeds internal peripherals
// - enable starts output without glitches
// - clearing enable stops output at once
// - ratio field divides by 1 to 128
// - duty 25/50/75 from divide-by-4 up; divide-by-2 gives 50 for codes 10/11 and 0 for 01/00, undivided ignores duty
// - ratio and duty changes accepted while enabled
// - duty upper bit resets to one
// - generator runs in system clock domain
// - sleep freezes reference output and divider state unless software writes
// - enable bit turns generator on, resets off
// - ratio code is power-of-two exponent
// - duty codes 11/10/01/00 give 75/50/25/0
`timescale 1ns/1ps
`default_nettype none

module rco_ref_clock (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [3:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic sleep_i, // device asleep, same domain
  input wire logic [5:0] periph_osc_req, // peripheral oscillator requests
  input wire logic [9:0] ref_src_i, // async source clocks, codes 1..10
  output rco_pkg::rco_osc_cfg_t osc_cfg, // oscillator configuration
  output logic ref_output_pin, // reference clock pin
  output logic ref_clk_int // reference clock to peripherals
);

  // every assertion below runs on the system clock; all but a_reset_duty rest in reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // nominal frequency in MHz, zero for reserved codes
  function automatic logic [7:0] nominal_mhz(input logic [3:0] code);
    case (code)
      4'h0: nominal_mhz = 8'h01;
      4'h1: nominal_mhz = 8'h02;
      4'h2: nominal_mhz = 8'h04;
      4'h3: nominal_mhz = 8'h08;
      4'h4: nominal_mhz = 8'h0c;
      4'h5: nominal_mhz = 8'h10;
      4'h6: nominal_mhz = 8'h20;
      4'h7: nominal_mhz = 8'h30;
      4'h8: nominal_mhz = 8'h40;
      default: nominal_mhz = 8'h00;
    endcase
  endfunction

  // period length in source ticks for a ratio code
  function automatic logic [7:0] period_of(input logic [2:0] ratio);
    period_of = 8'h01 << ratio;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [3:0] freq_sel_q;
  logic [5:0] trim_q;
  logic [5:0] manual_q;
  logic sosc_mode_q;
  logic ref_en_q;
  logic [1:0] duty_q;
  logic [2:0] ratio_q;
  logic [3:0] src_sel_q;
  logic wr_ctrl;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  assign wr_ctrl = reg_wr && (reg_addr == rco_pkg::REG_REF_CTRL);

  // oscillator configuration writes, unused bits dropped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      freq_sel_q <= rco_pkg::FREQ_SEL_RST;
      trim_q <= rco_pkg::TRIM_RST;
      manual_q <= rco_pkg::MANUAL_EN_RST;
      sosc_mode_q <= rco_pkg::SOSC_MODE_RST;
    end else if (reg_wr) begin
      if (reg_addr == rco_pkg::REG_FREQ_SEL) begin
        freq_sel_q <= reg_wdata[rco_pkg::FREQ_MSB:0];
      end else if (reg_addr == rco_pkg::REG_TRIM) begin
        trim_q <= reg_wdata[rco_pkg::TRIM_MSB:0];
      end else if (reg_addr == rco_pkg::REG_MANUAL_EN) begin
        manual_q <= reg_wdata[7:rco_pkg::MANUAL_LSB];
      end else if (reg_addr == rco_pkg::REG_SOSC_MODE) begin
        sosc_mode_q <= reg_wdata[0];
      end
    end
  end

  // reference control and source writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_en_q <= rco_pkg::REF_EN_RST;
      duty_q <= rco_pkg::DUTY_RST;
      ratio_q <= rco_pkg::RATIO_RST;
      src_sel_q <= rco_pkg::SRC_RST;
    end else if (reg_wr) begin
      if (wr_ctrl) begin
        ref_en_q <= reg_wdata[rco_pkg::REF_EN_POS];
        duty_q <= reg_wdata[rco_pkg::DUTY_LSB +: 2];
        ratio_q <= reg_wdata[rco_pkg::RATIO_LSB +: 3];
      end else if (reg_addr == rco_pkg::REG_REF_SRC) begin
        src_sel_q <= reg_wdata[rco_pkg::SRC_MSB:0];
      end
    end
  end

  // read mux, unmapped and unimplemented bits read zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == rco_pkg::REG_FREQ_SEL) begin
      rdata_d = {4'h0, freq_sel_q};
    end else if (reg_addr == rco_pkg::REG_TRIM) begin
      rdata_d = {2'h0, trim_q};
    end else if (reg_addr == rco_pkg::REG_MANUAL_EN) begin
      rdata_d = {manual_q, 2'h0};
    end else if (reg_addr == rco_pkg::REG_SOSC_MODE) begin
      rdata_d = {7'h00, sosc_mode_q};
    end else if (reg_addr == rco_pkg::REG_REF_CTRL) begin
      rdata_d = {ref_en_q, 2'h0, duty_q, ratio_q};
    end else if (reg_addr == rco_pkg::REG_REF_SRC) begin
      rdata_d = {4'h0, src_sel_q};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator control

  logic [5:0] osc_run;

  // manual bit or a peripheral request runs each oscillator; the mid
  // oscillator is a tap of the high one, so it keeps the high one alive
  always_comb begin
    osc_run = manual_q | periph_osc_req;
    osc_run[rco_pkg::OSC_HIGH] = osc_run[rco_pkg::OSC_HIGH]
      | osc_run[rco_pkg::OSC_MID];
  end

  // configuration to the analog oscillators
  always_comb begin
    osc_cfg.hf_freq_select = freq_sel_q;
    osc_cfg.hf_nominal_mhz = nominal_mhz(freq_sel_q);
    osc_cfg.hf_freq_reserved =
      freq_sel_q > rco_pkg::FREQ_MAX_CODE;
    osc_cfg.trim_offset = trim_q;
    osc_cfg.osc_run = osc_run;
    osc_cfg.secondary_osc_power_mode = sosc_mode_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // source synchronisation and selection

  logic [9:0] src_meta_q;
  logic [9:0] src_sync_q;
  logic sys_tgl_q;
  logic [3:0] src_use_q;
  logic src_lvl_d;
  logic src_prev_q;
  logic src_tick;

  // two flops on every asynchronous source
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      src_meta_q <= 10'h000;
      src_sync_q <= 10'h000;
    end else begin
      src_meta_q <= ref_src_i;
      src_sync_q <= src_meta_q;
    end
  end

  // system clock source seen as a level that flips every cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sys_tgl_q <= 1'b0;
    end else if (!sleep_i) begin
      sys_tgl_q <= ~sys_tgl_q;
    end
  end

  // selected level from the latched selection, reserved codes idle low
  always_comb begin
    src_lvl_d = 1'b0;
    if (src_use_q == rco_pkg::SRC_SYS) begin
      src_lvl_d = sys_tgl_q;
    end else if (src_use_q <= rco_pkg::SRC_LAST) begin
      src_lvl_d = src_sync_q[src_use_q - 4'h1];
    end
  end

  // a new selection is taken only while the old source is low and the
  // edge history is reloaded, so no partial pulse reaches the divider
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      src_use_q <= rco_pkg::SRC_RST;
      src_prev_q <= 1'b0;
    end else if (!sleep_i) begin
      if (src_use_q != src_sel_q && !src_lvl_d) begin
        src_use_q <= src_sel_q;
        src_prev_q <= 1'b1;
      end else begin
        src_prev_q <= src_lvl_d;
      end
    end
  end

  // one tick per rising edge of the chosen source; system clock ticks always
  assign src_tick = (src_use_q == rco_pkg::SRC_SYS) ? 1'b1
    : (src_lvl_d && !src_prev_q);

  ////////////////////////////////////////////////////////////////////////////
  // divider and duty

  logic [6:0] cnt_q;
  logic [7:0] period;
  logic [7:0] high_len;
  logic [9:0] high_prod;
  logic ref_out_q;

  assign period = period_of(ratio_q);
  assign high_prod = {2'h0, period} * {8'h00, duty_q};
  assign high_len = high_prod[9:2];

  // divide counter, held at zero while disabled
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= 7'h00;
    end else if (!ref_en_q
        || (wr_ctrl && !reg_wdata[rco_pkg::REF_EN_POS])) begin
      cnt_q <= 7'h00;
    end else if (!sleep_i && src_tick) begin
      cnt_q <= (cnt_q + 7'h01) & period[6:0] - 7'h01;
    end
  end

  // output level; cleared in the same edge that clears the enable, and
  // frozen while asleep
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_out_q <= 1'b0;
    end else if (wr_ctrl && !reg_wdata[rco_pkg::REF_EN_POS]) begin
      ref_out_q <= 1'b0;
    end else if (!ref_en_q) begin
      ref_out_q <= 1'b0;
    end else if (sleep_i) begin
      ref_out_q <= ref_out_q;
    end else if (ratio_q == 3'h0) begin
      ref_out_q <= src_lvl_d;
    end else if (src_tick) begin
      ref_out_q <= {1'b0, cnt_q} < high_len;
    end
  end

  assign ref_output_pin = ref_out_q;
  assign ref_clk_int = ref_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // clock comes from the default clocking and reset from the default disable iff at the module top;
  // only the reset check below overrides the reset guard

  // a cycle of the divide-by-two, half-duty, system-clock setting
  sequence s_fast_half;
    ref_en_q && src_use_q == rco_pkg::SRC_SYS && ratio_q == 3'h1
      && duty_q == 2'h2 && !sleep_i;
  endsequence

  // a disabling write clears output and counter at that very edge
  a_disable_stop: assert property (
    wr_ctrl && !reg_wdata[rco_pkg::REF_EN_POS]
      |=> !ref_out_q && cnt_q == 7'h00)
    else $error("output still active after disable");

  // a disabled generator keeps its output low
  a_off_low: assert property (
    !ref_en_q |=> !ref_out_q)
    else $error("output high while disabled");

  // the divide counter rests at its start while disabled
  a_cnt_held: assert property (
    !ref_en_q |-> cnt_q == 7'h00)
    else $error("counter moved while disabled");

  // enabling begins at a clean period edge
  a_start_clean: assert property (
    $rose(ref_en_q) |-> !ref_out_q && cnt_q == 7'h00)
    else $error("start did not begin at a period edge");

  // sleep freezes level and count unless software writes
  a_sleep_freeze: assert property (
    sleep_i && !reg_wr |=> $stable(ref_out_q) && $stable(cnt_q))
    else $error("output moved during sleep");

  // every forced oscillator is running
  a_manual_run: assert property (
    (manual_q & ~osc_cfg.osc_run) == 6'h00)
    else $error("forced oscillator not running");

  // the mid oscillator never runs without its high-frequency parent
  a_mid_needs_hf: assert property (
    osc_cfg.osc_run[rco_pkg::OSC_MID] |-> osc_cfg.osc_run[rco_pkg::OSC_HIGH])
    else $error("mid oscillator without high oscillator");

  // a zero duty setting drives every divided tick low
  a_duty_zero: assert property (
    ref_en_q && ratio_q != 3'h0 && duty_q == 2'h0 && src_tick
      && !sleep_i && !reg_wr |=> !ref_out_q)
    else $error("zero duty produced a high level");

  // unimplemented bits of the frequency select read zero
  a_reserved_zero: assert property (
    reg_rd && reg_addr == rco_pkg::REG_FREQ_SEL |=> reg_rdata[7:4] == 4'h0)
    else $error("unimplemented bits read nonzero");

  // read data is zero outside the cycle after a read strobe
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data present without a read");

  // three settled cycles of divide-by-two must keep toggling
  a_div2_toggle: assert property (
    s_fast_half ##1 s_fast_half ##1 s_fast_half
      |-> ref_out_q != $past(ref_out_q))
    else $error("divide by two did not toggle");

  // reset leaves half duty and the generator off, checked during reset
  a_reset_duty: assert property (disable iff (1'b0)
    sys_rst |=> duty_q == rco_pkg::DUTY_RST && !ref_en_q)
    else $error("duty field reset value wrong");

  // undivided output copies the chosen source level one edge later
  a_ratio0_follow: assert property (
    ref_en_q && ratio_q == 3'h0 && !sleep_i && !wr_ctrl
      |=> ref_out_q == $past(src_lvl_d))
    else $error("undivided output did not follow source");

  // reserved frequency codes report no nominal frequency
  a_freq_flag: assert property (
    osc_cfg.hf_freq_reserved == (osc_cfg.hf_nominal_mhz == 8'h00))
    else $error("reserved flag disagrees with nominal frequency");

  // the source selection only moves while the old level is low
  a_src_switch: assert property (
    $changed(src_use_q) |-> !$past(src_lvl_d))
    else $error("source switched while its level was high");

endmodule // rco_ref_clock

`default_nettype wire

// File: dv/rco_src_model.sv
`timescale 1ns/1ps
`default_nettype none

// source clocks: code k+1 has a half period of k+3 system cycles
module rco_src_model (
  output logic [9:0] src_o // source clocks for codes 1..10
);
  for (genvar k = 0; k < 10; k++) begin : g_src
    // 3 ns offset keeps edges clear of the system clock edge
    initial begin
      src_o[k] = 1'b0;
      #3;
      forever #((k + 3) * 10) src_o[k] = ~src_o[k];
    end
  end
endmodule // rco_src_model

`default_nettype wire

// File: dv/rco_ref_clock_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module rco_ref_clock_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_i = 1'b0;
  logic [5:0] periph_osc_req = 6'h00;
  wire logic [9:0] ref_src_i;
  logic [7:0] reg_rdata;
  rco_pkg::rco_osc_cfg_t osc_cfg;
  logic ref_output_pin;
  logic ref_clk_int;
  int num_errors = 0;
  int comparisons = 0;
  logic [7:0] rst_v [7] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
  logic [7:0] msk_v [7] = '{8'h0f, 8'h3f, 8'hfc, 8'h01, 8'h9f, 8'h0f, 8'h00};
  logic [7:0] mhz [16] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0c, 8'h10,
    8'h20, 8'h30, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  ////////////////////////////////////////////////////////////////////////
  // clock, design and source model
  always #5 clk_sys = ~clk_sys;

  rco_ref_clock dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_i(sleep_i),
    .periph_osc_req(periph_osc_req), .ref_src_i(ref_src_i),
    .osc_cfg(osc_cfg), .ref_output_pin(ref_output_pin),
    .ref_clk_int(ref_clk_int));

  rco_src_model src_model (.src_o(ref_src_i));

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic complete_run;
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // settle two output periods and eight cycles, then count high cycles and rises over two periods
  task automatic run_clk(logic [3:0] src, logic [7:0] ctrl, int per, int hi);
    int h;
    int r;
    logic p;
    h = 0;
    r = 0;
    wr(rco_pkg::REG_REF_SRC, {4'h0, src});
    wr(rco_pkg::REG_REF_CTRL, ctrl);
    repeat (2 * per + 8) @(posedge clk_sys);
    #1 p = ref_output_pin;
    repeat (2 * per) begin
      @(posedge clk_sys);
      #1 check("internal clock", ref_output_pin, ref_clk_int);
      h += ref_output_pin;
      r += (ref_output_pin && !p);
      p = ref_output_pin;
    end
    check("high cycles", 2 * hi, h);
    check("rising edges", (hi > 0) ? 2 : 0, r);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    logic [7:0] d;
    for (int a = 0; a < 7; a++) begin
      rd(a[3:0], d);
      check("reset value", rst_v[a], d);
    end
    for (int a = 0; a < 7; a++) begin
      wr(a[3:0], 8'hff);
      rd(a[3:0], d);
      check("written value", msk_v[a], d);
    end
    wr(rco_pkg::REG_TRIM, 8'h20);
    check("trim minimum", 6'h20, osc_cfg.trim_offset);
  endtask

  task automatic t_osc;
    for (int c = 0; c < 16; c++) begin
      wr(rco_pkg::REG_FREQ_SEL, c[7:0]);
      check("nominal", mhz[c], osc_cfg.hf_nominal_mhz);
      check("reserved", c > 8, osc_cfg.hf_freq_reserved);
      check("freq code", c[3:0], osc_cfg.hf_freq_select);
    end
    for (int i = 0; i < 6; i++) begin
      wr(rco_pkg::REG_MANUAL_EN, 8'h04 << i);
      check("forced run", (6'h01 << i) | ((i == rco_pkg::OSC_MID) ?
        6'h10 : 6'h00), osc_cfg.osc_run);
      wr(rco_pkg::REG_MANUAL_EN, 8'h00);
      check("idle run", 6'h00, osc_cfg.osc_run);
      @(posedge clk_sys);
      periph_osc_req <= 6'h01 << i;
      #1 check("request run", periph_osc_req | ((i == rco_pkg::OSC_MID) ?
        6'h10 : 6'h00), osc_cfg.osc_run);
      @(posedge clk_sys);
      periph_osc_req <= 6'h00;
    end
    wr(rco_pkg::REG_SOSC_MODE, 8'h01);
    check("power mode", 1'b1, osc_cfg.secondary_osc_power_mode);
    wr(rco_pkg::REG_SOSC_MODE, 8'h00);
    check("power mode", 1'b0, osc_cfg.secondary_osc_power_mode);
  endtask

  task automatic t_div;
    // ratio changes are written while running
    for (int r = 0; r < 8; r++)
      run_clk(4'h0, 8'h90 | r, (r == 0) ? 2 : (1 << r),
        (r == 0) ? 1 : (1 << r) / 2);
    for (int d = 0; d < 4; d++)
      run_clk(4'h0, 8'h82 | (d << 3), 4, d);
    run_clk(4'h0, 8'h88, 2, 1); // undivided
  endtask

  task automatic t_start_stop;
    wr(rco_pkg::REG_REF_CTRL, 8'h0a); // set up while off
    wr(rco_pkg::REG_REF_CTRL, 8'h8a);
    check("first level", 1'b0, ref_output_pin);
    @(posedge clk_sys);
    #1 check("first high", 1'b1, ref_output_pin);
    @(posedge clk_sys);
    #1 check("first low", 1'b0, ref_output_pin);
    wr(rco_pkg::REG_REF_CTRL, 8'h9f);
    repeat (3) @(posedge clk_sys);
    #1 check("long high", 1'b1, ref_output_pin);
    wr(rco_pkg::REG_REF_CTRL, 8'h1f);
    check("stopped", 1'b0, ref_output_pin);
    repeat (200) @(posedge clk_sys);
    #1 check("still off", 1'b0, ref_output_pin);
  endtask

  task automatic t_sleep;
    logic p;
    logic [7:0] d;
    wr(rco_pkg::REG_REF_CTRL, 8'h91);
    repeat (5) @(posedge clk_sys);
    sleep_i <= 1'b1;
    @(posedge clk_sys);
    #1 p = ref_output_pin;
    repeat (20) @(posedge clk_sys);
    #1 check("frozen", p, ref_output_pin);
    @(posedge clk_sys);
    sleep_i <= 1'b0;
    rd(rco_pkg::REG_REF_CTRL, d);
    check("kept ctrl", 8'h91, d);
    run_clk(4'h0, 8'h91, 2, 1); // resumes
  endtask

  task automatic t_ext;
    run_clk(4'h1, 8'h91, 12, 6);
    run_clk(4'ha, 8'h80, 24, 12);
    run_clk(4'hb, 8'h80, 12, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_osc;
    t_div;
    t_start_stop;
    t_sleep;
    t_ext;
    complete_run;
  end

  initial begin
    #200000;
    num_errors++;
    complete_run;
  end
endmodule // rco_ref_clock_tb_top

`default_nettype wire
